// [rtl/sodc_top.sv]
// Purpose: Serial opcode decoder of the converter front-end
// Assumes: Serial pins are asynchronous; clk is the master clock
// Notes:   Serial mode 1: sample on falling, drive on rising edge
`timescale 1ns/10ps
`default_nettype none
`include "sodc_defs.svh"

module sodc_top
    import sodc_pkg::*;
#(
    parameter int RESULT_W = 32
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                din,
    output logic                     dout,
    output logic                     dout_oe,
    input  wire logic                start_pin,
    input  wire logic                conv_done,
    input  wire logic [RESULT_W-1:0] conv_data,
    output logic [4:0]               reg_rd_addr,
    input  wire logic [7:0]          reg_rd_data,
    output sodc_pkg::sodc_wr_t       reg_wr,
    output logic                     reg_wr_valid,
    input  wire logic                reg_wr_ready,
    output logic                     conv_run,
    output logic                     standby,
    output logic                     soft_reset,
    output logic                     cont_mode,
    output logic                     result_ready_n,
    output logic                     wr_overrun
);
    import sodc_pkg::*;

    // Pin synchronisers; stage 0 feeds stage 1 only
    logic [2:0]  sclk_sy;
    logic [1:0]  cs_sy;
    logic [1:0]  din_sy;
    logic [1:0]  start_sy;

    sodc_state_t          st_q;
    sodc_state_t          st_d;
    logic [2:0]           bit_q;
    logic [7:0]           rx_q;
    logic [4:0]           addr_q;
    logic [4:0]           cnt_q;
    logic [4:0]           rst_cnt_q;
    logic                 run_q;
    logic                 stopping_q;
    logic                 standby_q;
    logic                 cont_q;
    logic                 ld_q;
    logic                 rdp_q;
    logic                 rdy_n_q;
    logic                 ovr_q;
    logic                 wr_dir_q;
    logic                 dout_q;
    logic [RESULT_W-1:0]  sh_q;
    logic [RESULT_W-1:0]  result_q;
    logic                 buf_in_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sy  <= 3'h0;
            cs_sy    <= 2'h3;
            din_sy   <= 2'h0;
            start_sy <= 2'h0;
        end else begin
            sclk_sy  <= {sclk_sy[1:0], sclk};
            cs_sy    <= {cs_sy[0], cs_n};
            din_sy   <= {din_sy[0], din};
            start_sy <= {start_sy[0], start_pin};
        end
    end

    wire cs_act  = ~cs_sy[1];
    wire din_s   = din_sy[1];
    wire sc_rise = sclk_sy[1] & ~sclk_sy[2] & cs_act;
    wire sc_fall = ~sclk_sy[1] & sclk_sy[2] & cs_act;

    // Byte framing
    wire       edge7   = sc_fall & (bit_q == `SODC_BIT_SYS);
    wire       edge8   = sc_fall & (bit_q == `SODC_BIT_LAST);
    wire [7:0] rx_byte = {rx_q[6:0], din_s};
    // Last bit of a system opcode is always zero
    wire [7:0] op7     = {rx_q[5:0], din_s, 1'b0};

    wire busy     = (rst_cnt_q != 5'h00);
    wire op_phase = (st_q == ST_OP) & ~busy;
    wire take7    = edge7 & op_phase;
    wire take8    = edge8 & op_phase;

    wire do_wake  = take7 & (op7 == `SODC_OP_WAKE);
    wire do_stby  = take7 & (op7 == `SODC_OP_STBY);
    wire do_reset = take7 & (op7 == `SODC_OP_RESET);
    wire do_start = take7 & (op7 == `SODC_OP_START);
    wire do_stop  = take7 & (op7 == `SODC_OP_STOP);
    wire do_rdata = take7 & (op7 == `SODC_OP_RDATA);
    wire do_rdc   = take8 & (rx_byte == `SODC_OP_RDC);
    wire do_sdc   = take8 & (rx_byte == `SODC_OP_SDC);
    wire is_rd    = (rx_byte[7:5] == `SODC_PFX_RD);
    wire is_wr    = (rx_byte[7:5] == `SODC_PFX_WR);
    wire register_read_cmd_hit = take8 & is_rd & ~cont_q;
    wire register_write_cmd_hit = take8 & is_wr;
    wire cnt_ok   = (rx_byte[7:5] == `SODC_PFX_CNT);
    wire cnt_take = edge8 & (st_q == ST_CNT);
    wire last_reg = (cnt_q == 5'h00);
    wire rd_next  = edge8 & (st_q == ST_RD);
    wire wr_push  = edge8 & (st_q == ST_WR);

    // Conversions run by pin or by opcode
    wire run_eff   = start_sy[1] | run_q;
    wire conv_cap  = conv_done & run_eff;
    wire cont_ld   = conv_cap & cont_q & (st_q == ST_OP) & ~ld_q;
    wire rdata_ld  = rdp_q & edge8;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_OP: begin
                if (register_read_cmd_hit | register_write_cmd_hit) st_d = ST_CNT;
                else if (take8 & is_rd) st_d = ST_SKIP;
            end
            ST_CNT: begin
                if (cnt_take) st_d = !cnt_ok ? ST_SKIP
                                   : (wr_dir_q ? ST_WR : ST_RD);
            end
            ST_RD: begin
                if (rd_next & last_reg) st_d = ST_SKIP;
            end
            ST_WR: begin
                if (wr_push & last_reg) st_d = ST_SKIP;
            end
            ST_SKIP: st_d = ST_SKIP;
            default: st_d = ST_OP;
        endcase
        // Deselect always ends a command
        if (!cs_act) st_d = ST_OP;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q  <= ST_OP;
            bit_q <= 3'h0;
            rx_q  <= 8'h00;
        end else begin
            st_q <= st_d;
            if (!cs_act) bit_q <= 3'h0;
            else if (sc_fall) bit_q <= bit_q + 3'h1;
            if (sc_fall) rx_q <= rx_byte;
        end
    end

    // Remembers the opcode's direction for the count byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q   <= 5'h00;
            cnt_q    <= 5'h00;
            wr_dir_q <= 1'b0;
        end else if (register_read_cmd_hit | register_write_cmd_hit) begin
            addr_q   <= rx_byte[4:0];
            wr_dir_q <= is_wr;
        end else if (cnt_take) begin
            cnt_q  <= rx_byte[4:0];
        end else if ((rd_next | wr_push) & ~last_reg) begin
            addr_q <= addr_q + 5'h01;
            cnt_q  <= cnt_q - 5'h01;
        end
    end

    // Soft reset hold counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rst_cnt_q <= 5'h00;
        else if (do_reset) rst_cnt_q <= `SODC_RST_CYC;
        else if (busy) rst_cnt_q <= rst_cnt_q - 5'h01;
    end

    // Mode state; soft reset returns defaults
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standby_q <= 1'b0;
            cont_q    <= 1'b1;
        end else if (do_reset) begin
            standby_q <= 1'b0;
            cont_q    <= 1'b1;
        end else begin
            if (do_stby) standby_q <= 1'b1;
            else if (do_wake) standby_q <= 1'b0;
            if (do_rdc) cont_q <= 1'b1;
            else if (do_sdc) cont_q <= 1'b0;
        end
    end

    // Stop waits for the running conversion to end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q      <= 1'b0;
            stopping_q <= 1'b0;
        end else if (do_reset) begin
            run_q      <= 1'b0;
            stopping_q <= 1'b0;
        end else if (do_start) begin
            run_q      <= 1'b1;
            stopping_q <= 1'b0;
        end else if (do_stop & run_q) begin
            stopping_q <= 1'b1;
        end else if (stopping_q & conv_done) begin
            run_q      <= 1'b0;
            stopping_q <= 1'b0;
        end
    end

    // Result copy stays for repeated reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= '0;
            rdy_n_q  <= 1'b1;
        end else if (conv_cap) begin
            result_q <= conv_data;
            rdy_n_q  <= 1'b0;
        end else if (sc_rise) begin
            rdy_n_q  <= 1'b1;
        end
    end

    // Register fetch is one cycle behind the address step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ld_q  <= 1'b0;
            rdp_q <= 1'b0;
        end else begin
            ld_q <= (cnt_take & cnt_ok & ~wr_dir_q)
                  | (rd_next & ~last_reg);
            if (!cs_act | rdata_ld) rdp_q <= 1'b0;
            else if (do_rdata & run_eff) rdp_q <= 1'b1;
        end
    end

    // Output shift; load comes well before the next rising edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_q   <= '0;
            dout_q <= 1'b0;
        end else if (ld_q) begin
            sh_q <= {reg_rd_data, {(RESULT_W-8){1'b0}}};
        end else if (rdata_ld) begin
            sh_q <= result_q;
        end else if (cont_ld) begin
            sh_q <= conv_data;
        end else if (sc_rise) begin
            dout_q <= sh_q[RESULT_W-1];
            sh_q   <= {sh_q[RESULT_W-2:0], 1'b0};
        end
    end

    // Host cannot be stalled; a full buffer drops and flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ovr_q <= 1'b0;
        else if (wr_push & ~buf_in_ready) ovr_q <= 1'b1;
    end

    wire [$bits(sodc_wr_t)-1:0] buf_out;
    sodc_wr_t wr_word;
    assign wr_word = '{addr: addr_q, data: rx_byte};

    sodc_buf2 #(
        .W     ($bits(sodc_wr_t)),
        .DEPTH (2)
    ) u_wbuf (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (wr_push),
        .in_ready  (buf_in_ready),
        .in_data   (wr_word),
        .out_valid (reg_wr_valid),
        .out_ready (reg_wr_ready),
        .out_data  (buf_out)
    );

    assign reg_wr         = sodc_wr_t'(buf_out);
    assign reg_rd_addr    = addr_q;
    assign dout           = dout_q;
    assign dout_oe        = cs_act;
    assign conv_run       = run_eff;
    assign standby        = standby_q;
    assign soft_reset     = busy;
    assign cont_mode      = cont_q;
    assign result_ready_n = rdy_n_q;
    assign wr_overrun     = ovr_q;

    chk_reset_len: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(soft_reset) |-> ##17 soft_reset ##1 !soft_reset)
        else $error("soft reset length wrong");

    chk_stby_enter: assert property (@(posedge clk) disable iff (!arst_n)
        do_stby |=> standby ##1 (standby || $past(do_wake || do_reset)))
        else $error("standby not entered");

    chk_wake_exit: assert property (@(posedge clk) disable iff (!arst_n)
        do_wake && standby |=> !standby)
        else $error("standby not left");

    chk_start_keep: assert property (@(posedge clk) disable iff (!arst_n)
        do_start |=> run_q && !stopping_q)
        else $error("start did not run");

    chk_stop_finish: assert property (@(posedge clk) disable iff (!arst_n)
        do_stop && run_q && !conv_done |=> run_q && stopping_q
        ##1 (run_q || $past(conv_done)))
        else $error("stop cut conversion");

    chk_register_read_cmd_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        take8 && is_rd && cont_q && cs_act |=> st_q == ST_SKIP)
        else $error("read taken in continuous");

    chk_unknown_op: assert property (@(posedge clk) disable iff (!arst_n)
        take8 && rx_byte == 8'hFF |=> $stable(cont_q) && $stable(run_q)
        && $stable(standby_q) && st_q == ST_OP)
        else $error("unknown opcode acted");

    chk_addr_step: assert property (@(posedge clk) disable iff (!arst_n)
        (rd_next || wr_push) && !last_reg |=>
        addr_q == $past(addr_q) + 5'h01 && cnt_q == $past(cnt_q) - 5'h01)
        else $error("address not consecutive");

    chk_register_read_cmd_msb: assert property (@(posedge clk) disable iff (!arst_n)
        ld_q |=> sh_q[RESULT_W-1] == $past(reg_rd_data[7]))
        else $error("register MSB not loaded");

    chk_cont_load: assert property (@(posedge clk) disable iff (!arst_n)
        cont_ld && !rdata_ld |=> sh_q == $past(conv_data) && !result_ready_n)
        else $error("continuous load missed");

endmodule
`default_nettype wire

// [rtl/sodc_defs.svh]
// Purpose: Constants of the serial opcode decoder
// Assumes: Master clock is the block clock
// Notes:   Opcodes, prefixes and wait counts
`ifndef SODC_DEFS_SVH
`define SODC_DEFS_SVH

`define SODC_OP_WAKE   8'h02
`define SODC_OP_STBY   8'h04
`define SODC_OP_RESET  8'h06
`define SODC_OP_START  8'h08
`define SODC_OP_STOP   8'h0A
`define SODC_OP_RDC    8'h10
`define SODC_OP_SDC    8'h11
`define SODC_OP_RDATA  8'h12

`define SODC_PFX_RD    3'h1
`define SODC_PFX_WR    3'h2
`define SODC_PFX_CNT   3'h0

// Master clock cycles taken by a soft reset
`define SODC_RST_CYC   5'h12
`define SODC_BIT_SYS   3'h6
`define SODC_BIT_LAST  3'h7

`endif

// [rtl/sodc_pkg.sv]
// Purpose: Types of the serial opcode decoder
// Assumes: Nothing
// Notes:   Constants live in sodc_defs.svh
package sodc_pkg;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } sodc_wr_t;

    typedef enum logic [4:0] {
        ST_OP   = 5'h01,
        ST_CNT  = 5'h02,
        ST_RD   = 5'h04,
        ST_WR   = 5'h08,
        ST_SKIP = 5'h10
    } sodc_state_t;

endpackage

// [rtl/sodc_buf2.sv]
// Purpose: Small valid/ready buffer for register writes
// Assumes: Single clock, both sides on clk
// Notes:   Full and empty are exact
`timescale 1ns/10ps
`default_nettype none
module sodc_buf2 #(
    parameter int W     = 13,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    wire [AW-1:0] wp_nx = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    wire [AW-1:0] rp_nx = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_nx;
            if (pop) rp_q <= rp_nx;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; out_valid masks it
    always_ff @(posedge clk) begin
        if (push) mem_q[wp_q] <= in_data;
    end

endmodule
`default_nettype wire

// [sim/sodc_host.sv]
// Purpose: Host model, master of the serial port
// Assumes: Pins move on clk rising edges; 8 clk per sclk period
// Notes:   sclk rests low and din shows junk outside frames
`timescale 1ns/10ps
`default_nettype none
module sodc_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic open_frame();
        cs_n <= 1'b0;
        tick(4);
    endtask

    // A byte spans 64 clk, far over the decode gap
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b1;
            din  <= tx[i];
            tick(4);
            // Sampled just before the fall; a released pin reads 0
            rx[i] = dout & dout_oe;
            sclk <= 1'b0;
            tick(4);
        end
    endtask

    // Gap after every command covers the decode waits, not the 18-cycle soft reset
    task automatic close_frame();
        cs_n <= 1'b1;
        din  <= ~din;
        tick(8);
    endtask
endmodule
`default_nettype wire

// [sim/sodc_top_bench.sv]
// Purpose: Self-checking bench of the serial opcode decoder
// Assumes: Host model drives the serial pins; bench models registers
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module sodc_top_bench;
    import sodc_pkg::*;
    localparam int RW = 32;
    logic          clk, arst_n, sclk, cs_n, din, dout, dout_oe;
    logic          start_pin, conv_done, reg_wr_valid, reg_wr_ready;
    logic          conv_run, standby, soft_reset, cont_mode;
    logic          result_ready_n, wr_overrun, hold_rdy;
    logic [RW-1:0] conv_data, w, d;
    logic [4:0]    reg_rd_addr;
    logic [7:0]    reg_rd_data;
    sodc_wr_t      reg_wr;
    logic [7:0]    regs [32];
    logic [7:0]    exp_r [32];
    logic [31:0]   rs;
    logic [31:0]   ws = 32'h45;
    logic [4:0]    snap;
    logic [7:0]    bad_ops [5] = '{8'h0C, 8'h14, 8'h60, 8'hFF, 8'h80};
    int            sr_len, sr_base, n_mismatch, total_checks, i;

    sodc_top #(.RESULT_W(RW)) sodc_top_i (
        .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe),
        .start_pin(start_pin), .conv_done(conv_done),
        .conv_data(conv_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .reg_wr(reg_wr),
        .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
        .conv_run(conv_run), .standby(standby), .soft_reset(soft_reset),
        .cont_mode(cont_mode), .result_ready_n(result_ready_n),
        .wr_overrun(wr_overrun));
    sodc_host sodc_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Arbitrary register defaults, distinct per address
    function automatic logic [7:0] dflt(input int a);
        return {3'h5, 5'(a)};
    endfunction

    // Register file stand-in with a randomly stalling write port
    assign reg_rd_data = regs[reg_rd_addr];
    always @(posedge clk) begin
        ws <= xs(ws);
        reg_wr_ready <= ~hold_rdy & ws[3];
        if (!arst_n) begin
            for (int a = 0; a < 32; a++) regs[a] <= dflt(a);
        end else if (soft_reset) begin
            sr_len <= sr_len + 1;
            for (int a = 0; a < 32; a++) regs[a] <= dflt(a);
        end else if (reg_wr_valid && reg_wr_ready) begin
            regs[reg_wr.addr] <= reg_wr.data;
        end
    end

    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic cmd(input logic [7:0] op);
        logic [7:0] b;
        sodc_host_i.open_frame();
        sodc_host_i.xfer(op, b);
        sodc_host_i.close_frame();
    endtask

    task automatic done_pulse(input logic [RW-1:0] v);
        conv_data <= v;
        conv_done <= 1'b1;
        cyc(1);
        conv_done <= 1'b0;
        cyc(3);
    endtask

    // Result readout, with or without the read opcode in front
    task automatic read_out(input logic use_op, output logic [RW-1:0] v);
        logic [7:0] b;
        sodc_host_i.open_frame();
        if (use_op) sodc_host_i.xfer(8'h12, b);
        for (int k = 0; k < RW / 8; k++) begin
            sodc_host_i.xfer(8'h00, b);
            v = {v[RW-9:0], b};
        end
        sodc_host_i.close_frame();
    endtask

    // Bytes past the buffer's room are expected to be lost
    task automatic wr_regs(input logic [4:0] a, input int n, input int keep);
        logic [7:0] b;
        sodc_host_i.open_frame();
        sodc_host_i.xfer({3'h2, a}, b);
        sodc_host_i.xfer({3'h0, 5'(n - 1)}, b);
        for (int k = 0; k < n; k++) begin
            rs = xs(rs);
            sodc_host_i.xfer(rs[7:0], b);
            if (k < keep) exp_r[a + 5'(k)] = rs[7:0];
        end
        sodc_host_i.close_frame();
    endtask

    task automatic rd_regs(input logic [4:0] a, input int n, input logic ign);
        logic [7:0] b;
        sodc_host_i.open_frame();
        sodc_host_i.xfer({3'h1, a}, b);
        sodc_host_i.xfer({3'h0, 5'(n - 1)}, b);
        for (int k = 0; k < n; k++) begin
            sodc_host_i.xfer(8'h00, b);
            if (!ign) chk(b, exp_r[a + 5'(k)]);
        end
        sodc_host_i.close_frame();
    endtask

    initial begin
        arst_n = 1'b0;
        start_pin = 1'b0;
        conv_done = 1'b0;
        conv_data = '0;
        hold_rdy = 1'b0;
        rs = 69;
        n_mismatch = 0;
        total_checks = 0;
        for (int a = 0; a < 32; a++) exp_r[a] = dflt(a);
        cyc(16);
        arst_n <= 1'b1;
        cyc(4);
        chk({cont_mode, standby, soft_reset, result_ready_n, reg_wr_valid,
             wr_overrun}, 6'h24);
        // Continuous readout straight after reset, pin-started
        start_pin <= 1'b1;
        cyc(4);
        rs = xs(rs);
        d = rs;
        done_pulse(d);
        chk(result_ready_n, 1'b0);
        read_out(1'b0, w);
        chk(w, d);
        chk(result_ready_n, 1'b1);
        rd_regs(5'h05, 1, 1'b1);
        chk(reg_rd_addr, 5'h00);
        cmd(8'h11);
        chk(cont_mode, 1'b0);
        for (i = 1; i <= 3; i++) begin
            rs = xs(rs);
            // Address kept, since the write draws more randoms
            snap = 5'(rs[4:0] % 29);
            wr_regs(snap, i, i);
            rd_regs(snap, i, 1'b0);
        end
        wr_regs(5'h00, 32, 32);
        rd_regs(5'h00, 32, 1'b0);
        cmd(8'h04);
        chk(standby, 1'b1);
        cmd(8'h02);
        chk(standby, 1'b0);
        cmd(8'h02);
        chk(standby, 1'b0);
        start_pin <= 1'b0;
        cyc(4);
        chk(conv_run, 1'b0);
        cmd(8'h08);
        chk(conv_run, 1'b1);
        cmd(8'h08);
        chk(conv_run, 1'b1);
        cmd(8'h0A);
        chk(conv_run, 1'b1);
        rs = xs(rs);
        done_pulse(rs);
        chk(conv_run, 1'b0);
        cmd(8'h0A);
        chk(conv_run, 1'b0);
        cmd(8'h08);
        rs = xs(rs);
        d = rs;
        done_pulse(d);
        read_out(1'b1, w);
        chk(w, d);
        cmd(8'h10);
        chk(cont_mode, 1'b1);
        rs = xs(rs);
        d = rs;
        done_pulse(d);
        read_out(1'b0, w);
        chk(w, d);
        cmd(8'h11);
        snap = {conv_run, standby, cont_mode, reg_wr_valid, wr_overrun};
        foreach (bad_ops[k]) begin
            cmd(bad_ops[k]);
            chk({conv_run, standby, cont_mode, reg_wr_valid, wr_overrun},
                snap);
        end
        // Stalled consumer: two bytes fit, the third is refused
        hold_rdy <= 1'b1;
        cyc(2);
        wr_regs(5'h10, 3, 2);
        chk({reg_wr_valid, wr_overrun}, 2'h3);
        hold_rdy <= 1'b0;
        for (i = 0; i < 200 && reg_wr_valid !== 1'b0; i++) cyc(1);
        chk(reg_wr_valid, 1'b0);
        if (i == 200) test_done();
        rd_regs(5'h10, 3, 1'b0);
        sr_base = sr_len;
        cmd(8'h06);
        for (i = 0; i < 40 && soft_reset !== 1'b0; i++) cyc(1);
        if (i == 40) begin
            n_mismatch++;
            test_done();
        end
        chk(sr_len - sr_base, 18);
        chk({cont_mode, standby, conv_run}, 3'h4);
        for (int a = 0; a < 32; a++) exp_r[a] = dflt(a);
        cmd(8'h11);
        rd_regs(5'h10, 3, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
